// >>> dv/csi_master_model.sv
`timescale 1ns/1ps
module csi_master_model #(
  parameter int HALF = 12 // half period in clocks, well over three ticks
) (
  input wire logic clock, // system clock
  input wire logic go, // start one word
  input wire logic inv, // pin idles low when set
  input wire logic phase, // data half a period early
  input wire logic lsbFirst, // bit order
  input wire logic [3:0] bits, // word length
  input wire logic [7:0] txWord, // word to send
  input wire logic miso, // slave data line
  output logic sclk, // serial clock
  output logic mosi, // data to slave
  output logic [7:0] rxWord, // word received
  output logic busy // frame under way
);
  int idx;
  initial begin
    sclk = 1'b1;
    mosi = 1'b0;
    rxWord = 8'h00;
    busy = 1'b0;
  end
  // clock stands at idle outside frames; data line shows the inverse once released
  always @(posedge clock) begin
    if (go && !busy) begin
      busy <= 1'b1;
      rxWord <= 8'h00;
      for (int i = 0; i < bits; i++) begin
        idx = lsbFirst ? i : bits - 1 - i;
        mosi <= txWord[idx];
        if (phase) repeat (HALF) @(posedge clock);
        sclk <= inv;
        if (phase) rxWord[idx] <= miso;
        repeat (HALF) @(posedge clock);
        sclk <= ~inv;
        if (!phase) rxWord[idx] <= miso;
        repeat (HALF) @(posedge clock);
      end
      mosi <= ~mosi;
      busy <= 1'b0;
    end else if (!busy) begin
      sclk <= ~inv;
    end
  end
endmodule

// >>> dv/csi_slave_channel_bench.sv
`timescale 1ns/1ps
`include "csi_slave_map.svh"
module csi_slave_channel_bench;
  import csi_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h3;
  logic wvalid = 1'b0;
  logic wready;
  csi_resp_t bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  csi_resp_t rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic serialClkIn;
  logic serialDataIn;
  logic serialDataOut;
  logic serialDataOutEn;
  logic serialIrq;
  logic go = 1'b0;
  logic mInv = 1'b0;
  logic mPh = 1'b0;
  logic mLsb = 1'b0;
  logic [3:0] mBits = 4'h8;
  logic [7:0] mTx = 8'h00;
  logic [7:0] mRx;
  logic mBusy;
  logic len8, lsb, ck, ph, op;
  logic [7:0] mask;
  logic [31:0] d;
  logic [31:0] irqs = 32'h0;
  csi_resp_t lastResp;
  int cycles = 0;
  int badCount = 0;
  int samplesChecked = 0;
  // undriven data pin shows the inverse of serialDataOut, never the last bit
  wire misoLine = serialDataOutEn ? serialDataOut : ~serialDataOut;
  csi_slave_channel csi_slave_channel_inst (.clock, .rst_n, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .serialClkIn, .serialDataIn, .serialDataOut,
    .serialDataOutEn, .serialIrq);
  csi_master_model csi_master_model_inst (.clock, .go, .inv(mInv), .phase(mPh),
    .lsbFirst(mLsb), .bits(mBits), .txWord(mTx), .miso(misoLine), .sclk(serialClkIn),
    .mosi(serialDataIn), .rxWord(mRx), .busy(mBusy));
  always #10 clock = ~clock;
  // interrupt pulses counted, plus a watchdog against hangs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (serialIrq === 1'b1) irqs <= irqs + 32'h1;
    if (cycles == 30000) begin
      badCount++;
      wrapUp();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ready goes up with the request and stays until the answer is sampled;
  // one idle edge after each access keeps ready from being set twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    lastResp = bresp;
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    lastResp = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic kick(input logic [7:0] w);
    mTx <= w;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
  endtask
  task automatic finish();
    while (mBusy) @(posedge clock);
    repeat (10) @(posedge clock);
  endtask
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    rd(`CSI_OFF_MODE, d);
    check(d, 32'(`CSI_RST_MODE));
    rd(`CSI_OFF_SETUP, d);
    check(d, 32'(`CSI_RST_SETUP));
    rd(`CSI_OFF_STATUS, d);
    check(d, 32'h0);
    rd(8'h30, d);
    check(d, 32'h0);
    check(lastResp, CSI_RESP_SLVERR);
    wr(8'h30, 32'h1);
    check(lastResp, CSI_RESP_SLVERR);
    wr(`CSI_OFF_SETUP, 32'h0085);
    rd(`CSI_OFF_SETUP, d);
    check(d, 32'h0085);
    // four framings: length, order, polarity, phase and operation clock
    for (int i = 0; i < 4; i++) begin
      len8 = (i != 2);
      lsb = i[0];
      ck = i[0] ^ i[1];
      ph = i[1];
      op = (i == 3);
      mask = len8 ? 8'hff : 8'h7f;
      mInv <= ck;
      mPh <= ph;
      mLsb <= lsb;
      mBits <= len8 ? 4'h8 : 4'h7;
      wr(`CSI_OFF_PRESCALE, 32'h10);
      wr(`CSI_OFF_MODE, {16'h0, op, 15'h0});
      wr(`CSI_OFF_SETUP, {16'h0, 2'h3, ph, ck, 4'h0, lsb, 6'h0, len8});
      wr(`CSI_OFF_OUTEN, 32'h1);
      wr(`CSI_OFF_DATA, 32'ha4c6);
      rd(`CSI_OFF_STATUS, d);
      check(d, 32'h20);
      irqs <= 32'h0;
      wr(`CSI_OFF_START, 32'h1);
      rd(`CSI_OFF_RUNNING, d);
      check(d, 32'h1);
      kick(8'h5b);
      finish();
      check(mRx, 8'hc6 & mask);
      rd(`CSI_OFF_DATA, d);
      check(d & 32'hff, 32'(8'h5b & mask));
      rd(`CSI_OFF_STATUS, d);
      // early data phase preloads the next word at once, so busy stays up while idle
      check(d, ph ? 32'h40 : 32'h0);
      check(irqs, 32'h1);
      wr(`CSI_OFF_STOP, 32'h1);
      rd(`CSI_OFF_RUNNING, d);
      check(d, 32'h0);
    end
    // continuous transmit: overwrite while full, then switch to transfer end mid-word
    mInv <= 1'b0;
    mPh <= 1'b0;
    mLsb <= 1'b0;
    mBits <= 4'h8;
    wr(`CSI_OFF_SETUP, 32'h8001);
    wr(`CSI_OFF_MODE, 32'h1);
    wr(`CSI_OFF_DATA, 32'h11);
    wr(`CSI_OFF_DATA, 32'h96);
    rd(`CSI_OFF_STATUS, d);
    check(d, 32'h20);
    irqs <= 32'h0;
    wr(`CSI_OFF_START, 32'h1);
    kick(8'h00);
    while (irqs == 32'h0) @(posedge clock);
    wr(`CSI_OFF_MODE, 32'h0);
    check(serialDataOutEn, 1'b1);
    finish();
    check(mRx, 8'h96);
    check(irqs, 32'h2);
    wr(`CSI_OFF_STOP, 32'h1);
    // receive only: two unread words give overrun
    wr(`CSI_OFF_SETUP, 32'h4001);
    wr(`CSI_OFF_MODE, 32'h0);
    check(serialDataOutEn, 1'b0);
    irqs <= 32'h0;
    wr(`CSI_OFF_START, 32'h1);
    kick(8'h3a);
    finish();
    kick(8'hd4);
    finish();
    rd(`CSI_OFF_STATUS, d);
    check(d, 32'h1);
    check(irqs, 32'h2);
    rd(`CSI_OFF_DATA, d);
    check(d & 32'hff, 32'hd4);
    wr(`CSI_OFF_STATUS, 32'h1);
    rd(`CSI_OFF_STATUS, d);
    check(d, 32'h0);
    wr(`CSI_OFF_STOP, 32'h1);
    wrapUp();
  end
endmodule

// >>> dv/csi_slave_chk.sv
`timescale 1ns/1ps
`include "csi_slave_map.svh"
module csi_slave_chk (
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic [31:0] wdata, // write data
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire csi_pkg::csi_resp_t bresp, // write response
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // read data
  input wire csi_pkg::csi_resp_t rresp, // read response
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic serialClkIn, // serial clock pin
  input wire logic serialDataOutEn, // data pin driven
  input wire logic serialIrq // interrupt pulse
);
  import csi_pkg::*;
  logic oeShadow;
  logic txShadow;
  logic clkSeen;
  logic [5:0] sinceEdge;
  // shadows only see same-edge address and data, the way the bench issues writes
  wire wrTake = awvalid && awready && wvalid && wready;
  wire oeHit = wrTake && awaddr == `CSI_OFF_OUTEN;
  wire txHit = wrTake && awaddr == `CSI_OFF_SETUP;
  wire pinEdge = clkSeen != serialClkIn;
  wire [5:0] next_since = pinEdge ? 6'h00 : (sinceEdge == 6'h3f ? sinceEdge : sinceEdge + 6'h01);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // enable shadows and cycles since the last serial clock edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      oeShadow <= 1'b0;
      txShadow <= 1'b0;
      clkSeen <= serialClkIn;
      sinceEdge <= 6'h3f;
    end else begin
      if (oeHit) oeShadow <= wdata[0];
      if (txHit) txShadow <= wdata[`CSI_SETUP_TXEN];
      clkSeen <= serialClkIn;
      sinceEdge <= next_since;
    end
  end
  irq_one_shot_a: assert property (serialIrq |=> !serialIrq)
    else $error("interrupt held over one cycle");
  irq_near_edge_a: assert property (serialIrq |-> sinceEdge < 6'h14)
    else $error("interrupt without serial clock activity");
  out_en_gate_a: assert property (serialDataOutEn |-> $past(oeShadow) && $past(txShadow))
    else $error("data pin driven without transmit enabled");
  reset_idle_a: assert property ($rose(rst_n) |-> awready && arready && !bvalid && !rvalid)
    else $error("bus not idle after reset");
  wr_answer_a: assert property (wrTake |-> ##[1:3] bvalid)
    else $error("write response late");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (arvalid && arready |=> rvalid && rdata[31:16] == 16'h0)
    else $error("read answer wrong");
  bad_read_a: assert property (arvalid && arready && araddr >= 8'h28 |=>
    rresp == CSI_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  cover property (serialIrq);
  cover property (bvalid && bresp == CSI_RESP_SLVERR);
  cover property ($rose(serialDataOutEn));
endmodule
bind csi_slave_channel csi_slave_chk csi_slave_chk_inst (.clock, .rst_n, .awaddr, .awvalid,
  .awready, .wdata, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .serialClkIn, .serialDataOutEn, .serialIrq);

// >>> include/csi_pkg.sv
package csi_pkg;

  // channel operating state
  typedef enum logic {
    CSI_STOPPED,
    CSI_RUNNING
  } csi_run_t;

  // axi response code
  typedef logic [1:0] csi_resp_t;

  localparam csi_resp_t CSI_RESP_OKAY = 2'h0;
  localparam csi_resp_t CSI_RESP_SLVERR = 2'h2;

endpackage

// >>> include/csi_slave_map.svh
`ifndef CSI_SLAVE_MAP_SVH
`define CSI_SLAVE_MAP_SVH

// register byte offsets
`define CSI_OFF_MODE 8'h00
`define CSI_OFF_SETUP 8'h04
`define CSI_OFF_DATA 8'h08
`define CSI_OFF_STATUS 8'h0c
`define CSI_OFF_OUTLVL 8'h10
`define CSI_OFF_OUTEN 8'h14
`define CSI_OFF_START 8'h18
`define CSI_OFF_STOP 8'h1c
`define CSI_OFF_RUNNING 8'h20
`define CSI_OFF_PRESCALE 8'h24

// mode register fields
`define CSI_MODE_IRQSRC 0
`define CSI_MODE_OPCLK 15

// setup register fields
`define CSI_SETUP_LEN 0
`define CSI_SETUP_MARKED 1
`define CSI_SETUP_ORDER 7
`define CSI_SETUP_CKPOL 12
`define CSI_SETUP_DPHASE 13
`define CSI_SETUP_RXEN 14
`define CSI_SETUP_TXEN 15

// status register fields
`define CSI_STAT_OVR 0
`define CSI_STAT_BFF 5
`define CSI_STAT_BUSY 6

// reset values
`define CSI_RST_MODE 16'h0020
`define CSI_RST_SETUP 16'h0087
`define CSI_RST_PRESCALE 16'h0000

// the external clock must run at or below the operation clock over this ratio
`define CSI_SCLK_MIN_RATIO 6

`endif

// >>> verilog/csi_slave_channel.sv
`timescale 1ns/1ps
`include "csi_slave_map.svh"
// Operation
// - a data write while buffer full replaces the pending transmit word
// - receive-only mode signals transfer end only, never buffer empty
// - transmit modes signal transfer end or buffer empty as configured
// - receive overrun is the only error, shown by its own flag
// - length bit clear gives 7-bit words, set gives 8-bit words
// - serial clock is sampled by operation clock; master keeps it slow
// - data phase bit set moves data half a serial clock earlier
// - clock polarity bit set inverts the serial clock
// - bit order bit clear sends msb first, set sends lsb first
// - operation clock select picks prescaler output a or b
// - interrupt source bit clear fires on transfer completion
// - marked setup bit exists only on channels 0 and 1, else reads one
// - serial words live in data register low byte, baud above
// - receive-only mode drives no serial data output
// - slave operation only on channels built as slave capable
// - writing the stop bit clears running status and stops the channel
module csi_slave_channel #(
  parameter int CHAN_INDEX = 0,      // channel number inside its unit
  parameter int CHAN_BIT = 0,        // bit of this channel in start/stop fields
  parameter bit SLAVE_CAPABLE = 1'b1 // channel supports slave operation
) (
  input wire logic clock,                    // system clock, 50 MHz
  input wire logic rst_n,                    // synchronous reset, active low
  input wire logic [7:0] awaddr,             // write address
  input wire logic awvalid,                  // write address valid
  output logic awready,                      // write address ready
  input wire logic [31:0] wdata,             // write data
  input wire logic [3:0] wstrb,              // write byte strobes
  input wire logic wvalid,                   // write data valid
  output logic wready,                       // write data ready
  output csi_pkg::csi_resp_t bresp,          // write response
  output logic bvalid,                       // write response valid
  input wire logic bready,                   // write response ready
  input wire logic [7:0] araddr,             // read address
  input wire logic arvalid,                  // read address valid
  output logic arready,                      // read address ready
  output logic [31:0] rdata,                 // read data
  output csi_pkg::csi_resp_t rresp,          // read response
  output logic rvalid,                       // read data valid
  input wire logic rready,                   // read data ready
  input wire logic serialClkIn,              // serial clock from the master
  input wire logic serialDataIn,             // serial data from the master
  output logic serialDataOut,                // serial data to the master
  output logic serialDataOutEn,              // high while the data pin is driven
  output logic serialIrq                     // channel interrupt, one-cycle pulse
);
  import csi_pkg::*;
  // applies byte strobes to the low half of a register
  function automatic logic [15:0] mergeLow(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
    mergeLow = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  // prescaler tick: low sel bits of the free counter all ones
  function automatic logic presTick(input logic [15:0] cnt, input logic [3:0] sel);
    logic [15:0] mask;
    mask = (16'h1 << sel) - 16'h1;
    presTick = (cnt & mask) == mask;
  endfunction
  // bit position for shift step cnt
  function automatic logic [2:0] bitIdx(input logic [3:0] cnt, input logic lsbFirst,
                                        input logic eight);
    logic [3:0] top;
    top = eight ? 4'h7 : 4'h6;
    bitIdx = lsbFirst ? cnt[2:0] : 3'(top - cnt);
  endfunction
  // register state
  logic [15:0] modeReg, setupReg, presSel, presCnt;
  logic [6:0] baudSet;
  logic [7:0] txBuf, rxData, txWord, rxShift;
  logic outLvl, outEn, bufFull, overrun, rxPend, loaded, sdoReg, prevClk;
  logic [3:0] bitCnt;
  csi_run_t runState;
  // pin synchronisers and filtered levels
  logic [2:0] clkSync, datSync;
  logic clkLvl, datLvl;
  // axi holding state
  logic awHeld, wHeld;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  // configuration decode
  wire irqSource = modeReg[`CSI_MODE_IRQSRC];
  wire opClkSel = modeReg[`CSI_MODE_OPCLK];
  wire eightBit = setupReg[`CSI_SETUP_LEN];
  wire lsbFirst = setupReg[`CSI_SETUP_ORDER];
  wire clkPol = setupReg[`CSI_SETUP_CKPOL];
  wire dataPhase = setupReg[`CSI_SETUP_DPHASE];
  wire txEn = setupReg[`CSI_SETUP_TXEN];
  wire rxEn = setupReg[`CSI_SETUP_RXEN];
  wire rxOnly = rxEn & ~txEn;
  wire running = runState == CSI_RUNNING;
  wire markedBit = (CHAN_INDEX < 2) ? setupReg[`CSI_SETUP_MARKED] : 1'b1;
  // operation clock tick: the serial clock is only looked at on these
  wire tickA = presTick(presCnt, presSel[3:0]);
  wire tickB = presTick(presCnt, presSel[7:4]);
  wire opTick = opClkSel ? tickB : tickA;
  wire effClk = clkLvl ^ clkPol;
  wire clkRise = opTick & effClk & ~prevClk;
  wire clkFall = opTick & ~effClk & prevClk;
  wire capture = running & (dataPhase ? clkFall : clkRise);
  wire launch = running & (dataPhase ? clkRise : clkFall);
  wire [3:0] lastCnt = eightBit ? 4'h7 : 4'h6;
  wire wordDone = capture & (bitCnt == lastCnt);
  wire [2:0] curIdx = bitIdx(bitCnt, lsbFirst, eightBit);
  wire [2:0] firstIdx = bitIdx(4'h0, lsbFirst, eightBit);
  wire loadNow = running & txEn & ~loaded & (dataPhase | (launch & bitCnt == 4'h0));
  wire bufEmptyEv = loadNow & bufFull;
  // received word with the bit just captured
  logic [7:0] rxNext;
  always_comb begin
    rxNext = rxShift;
    rxNext[curIdx] = datLvl;
  end
  // axi write decode
  wire wrFire = awHeld & wHeld & ~bvalid;
  wire wrMode = wrFire & awAddrQ == `CSI_OFF_MODE;
  wire wrSetup = wrFire & awAddrQ == `CSI_OFF_SETUP;
  wire wrData = wrFire & awAddrQ == `CSI_OFF_DATA;
  wire wrStatus = wrFire & awAddrQ == `CSI_OFF_STATUS;
  wire wrOutLvl = wrFire & awAddrQ == `CSI_OFF_OUTLVL;
  wire wrOutEn = wrFire & awAddrQ == `CSI_OFF_OUTEN;
  wire wrStart = wrFire & awAddrQ == `CSI_OFF_START;
  wire wrStop = wrFire & awAddrQ == `CSI_OFF_STOP;
  wire wrPres = wrFire & awAddrQ == `CSI_OFF_PRESCALE;
  wire wrHit = wrMode | wrSetup | wrData | wrStatus | wrOutLvl | wrOutEn | wrStart | wrStop |
               wrPres | (wrFire & awAddrQ == `CSI_OFF_RUNNING);
  wire dataLowWr = wrData & wStrbQ[0];
  wire startHit = wrStart & wStrbQ[0] & wDataQ[CHAN_BIT] & SLAVE_CAPABLE;
  wire stopHit = wrStop & wStrbQ[0] & wDataQ[CHAN_BIT];
  wire ovrClear = wrStatus & wStrbQ[0] & wDataQ[`CSI_STAT_OVR];
  // axi read decode
  wire rdFire = arvalid & arready;
  wire rdDataLow = rdFire & araddr == `CSI_OFF_DATA & rxEn;
  wire [15:0] setupView = {setupReg[15:2], markedBit, setupReg[0]};
  wire [15:0] statusView = {9'h0, loaded | (bitCnt != 4'h0), bufFull, 4'h0, overrun};
  wire [7:0] dataLowView = rxEn ? rxData : txBuf;
  logic [15:0] rdMux;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    case (araddr)
      `CSI_OFF_MODE: rdMux = modeReg;
      `CSI_OFF_SETUP: rdMux = setupView;
      `CSI_OFF_DATA: rdMux = {baudSet, 1'b0, dataLowView};
      `CSI_OFF_STATUS: rdMux = statusView;
      `CSI_OFF_OUTLVL: rdMux = {15'h0, outLvl};
      `CSI_OFF_OUTEN: rdMux = {15'h0, outEn};
      `CSI_OFF_START: rdMux = 16'h0;
      `CSI_OFF_STOP: rdMux = 16'h0;
      `CSI_OFF_RUNNING: rdMux = {15'h0, running};
      `CSI_OFF_PRESCALE: rdMux = presSel;
      default: begin
        rdMux = 16'h0;
        rdHit = 1'b0;
      end
    endcase
  end
  // handshake outputs: one write and one read in flight at a time
  assign awready = ~awHeld & ~bvalid;
  assign wready = ~wHeld & ~bvalid;
  assign arready = ~rvalid;
  // serial data pin: receive-only never drives it
  assign serialDataOut = (running & txEn) ? sdoReg : outLvl;
  assign serialDataOutEn = outEn & txEn;
  // axi write channel holding and response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= CSI_RESP_OKAY;
    end else begin
      if (awvalid & awready) begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid & wready) begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrHit ? CSI_RESP_OKAY : CSI_RESP_SLVERR;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // axi read channel: answer one cycle after the address is taken
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= CSI_RESP_OKAY;
    end else if (rdFire) begin
      rvalid <= 1'b1;
      rdata <= {16'h0, rdMux};
      rresp <= rdHit ? CSI_RESP_OKAY : CSI_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // configuration registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      modeReg <= `CSI_RST_MODE;
      setupReg <= `CSI_RST_SETUP;
      presSel <= `CSI_RST_PRESCALE;
      baudSet <= 7'h00;
      outLvl <= 1'b1;
      outEn <= 1'b0;
    end else begin
      // interrupt source may change mid-run; it is sampled per event
      if (wrMode) modeReg <= mergeLow(modeReg, wDataQ, wStrbQ);
      if (wrSetup) setupReg <= mergeLow(setupReg, wDataQ, wStrbQ);
      if (wrPres) presSel <= mergeLow(presSel, wDataQ, wStrbQ);
      if (wrData & wStrbQ[1]) baudSet <= wDataQ[15:9];
      if (wrOutLvl & wStrbQ[0]) outLvl <= wDataQ[0];
      if (wrOutEn & wStrbQ[0]) outEn <= wDataQ[0];
    end
  end
  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clkSync <= 3'h0;
      datSync <= 3'h0;
      clkLvl <= 1'b0;
      datLvl <= 1'b0;
      presCnt <= 16'h0;
    end else begin
      clkSync <= {clkSync[1:0], serialClkIn};
      datSync <= {datSync[1:0], serialDataIn};
      if (clkSync[1] == clkSync[2]) clkLvl <= clkSync[2];
      if (datSync[1] == datSync[2]) datLvl <= datSync[2];
      presCnt <= presCnt + 16'h1;
    end
  end
  // run control and serial shifting
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      runState <= CSI_STOPPED;
      prevClk <= 1'b0;
      bitCnt <= 4'h0;
      loaded <= 1'b0;
      txWord <= 8'h00;
      rxShift <= 8'h00;
      sdoReg <= 1'b1;
    end else begin
      if (opTick) prevClk <= effClk;
      if (stopHit) begin
        runState <= CSI_STOPPED;
        bitCnt <= 4'h0;
        loaded <= 1'b0;
      end else if (startHit) begin
        runState <= CSI_RUNNING;
        bitCnt <= 4'h0;
        loaded <= 1'b0;
        prevClk <= effClk;                              // no false edge at start
      end else begin
        if (loadNow) begin
          txWord <= txBuf;
          loaded <= 1'b1;
          sdoReg <= txBuf[firstIdx];
        end else if (launch & loaded) begin
          sdoReg <= txWord[curIdx];
        end
        if (capture) begin
          rxShift <= rxNext;
          bitCnt <= wordDone ? 4'h0 : bitCnt + 4'h1;
          if (wordDone) loaded <= 1'b0;
        end
      end
    end
  end
  // data buffer, flags and interrupt pulse; hardware set beats software clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      txBuf <= 8'h00;
      rxData <= 8'h00;
      bufFull <= 1'b0;
      overrun <= 1'b0;
      rxPend <= 1'b0;
      serialIrq <= 1'b0;
    end else begin
      if (dataLowWr) begin
        txBuf <= wDataQ[7:0];
        bufFull <= 1'b1;
      end else if (loadNow) begin
        bufFull <= 1'b0;
      end
      if (wordDone & rxEn) begin
        rxData <= eightBit ? rxNext : {1'b0, rxNext[6:0]};
        rxPend <= 1'b1;
      end else if (rdDataLow) begin
        rxPend <= 1'b0;
      end
      if (wordDone & rxEn & rxPend & ~rdDataLow) begin
        overrun <= 1'b1;
      end else if (ovrClear) begin
        overrun <= 1'b0;
      end
      // receive-only ignores a buffer-empty selection
      if (irqSource & ~rxOnly) begin
        serialIrq <= bufEmptyEv & running;
      end else begin
        serialIrq <= wordDone;
      end
    end
  end
endmodule
